// *** src/osd_serial_command_decoder.sv ***
/*
 Serial command front end of an on-screen character display: shifts in
 8-bit words, decodes them over two banks, holds the character store and
 display settings, and gates the dot oscillator on horizontal sync.
 Assumes every pin input is asynchronous to clk_i and that the serial
 clock is much slower than clk_i (at least four clocks per level).
*/
// What this block does
// - Each serial clock rise shifts the data bit into an 8-bit register.
// - Strobe rise takes the whole 8-bit word and executes it.
// - After a character word, strobe fall advances the write address.
// - 111111 words select bank and format reset; bank 1 sets test mode.
// - Bank 0 carries character codes and per-character blink and colour.
// - Bank 0 row command loads a 4-bit row index.
// - Bank 0 column command loads a 5-bit column index.
// - Bank 0 loads display, blink, oscillator, fringe and background.
// - Bank 1 loads double-speed select and vertical start position.
// - Bank 1 loads the horizontal start position.
// - Bank 1 loads two size bits into the chosen row's size register.
// - Hold low stops the oscillator and forces colour and blanking low.
// - Monitor output is high when any colour output is high.
// - Oscillator runs only while horizontal sync is high, restarted on rise.
// - Clock output is the inverse of the oscillator output.
// - Bank select decides how later words are decoded.
// - In test mode only format selection and bank 1 test words are accepted.
// - Format reset clears every row size register to zero.
`timescale 1ns/1ps
`include "osd_params.svh"
module osd_serial_command_decoder #(
   parameter int ROWS = 12,
   parameter int COLS = 24
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_data_i,
   input wire logic serial_clk_i,
   input wire logic command_strobe_i,
   input wire logic hsync_i,
   input wire logic hold_i,
   input wire logic [3:0] scan_row_i,
   input wire logic [4:0] scan_col_i,
   output logic busy_o,
   output logic red_char_out_o,
   output logic green_char_out_o,
   output logic blue_char_out_o,
   output logic video_blanking_out_o,
   output logic char_activity_monitor_o,
   output logic osc_out_o,
   output logic osc_clock_out_o,
   output osd_pkg::osd_cell_t scan_cell_o,
   output logic bank_select_bit_o,
   output logic test_mode_o,
   output logic [3:0] test_code_o,
   output logic [3:0] row_index_o,
   output logic [4:0] column_index_o,
   output osd_pkg::osd_attr_t char_attr_o,
   output logic display_enable_o,
   output logic [1:0] blink_rate_o,
   output logic osc_enable_o,
   output logic [1:0] fringe_ctrl_o,
   output logic [1:0] background_style_o,
   output logic [2:0] background_color_o,
   output logic double_speed_select_o,
   output logic [4:0] vertical_position_o,
   output logic [4:0] horizontal_position_o,
   output logic [2*ROWS-1:0] char_size_o
);
   import osd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   ////////////////////////////////////////////////////////////////////////
   logic [4:0] pin_meta_reg;
   logic [4:0] pin_sync_reg;
   logic [4:0] pin_prev_reg;
   wire [4:0] pins = {hold_i, hsync_i, command_strobe_i,
                      serial_clk_i, serial_data_i};

   // Two stages, then one more for edge detection off the clean copy
   always_ff @(posedge clk_i) begin
      pin_meta_reg <= pins;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
   end

   wire data_s = pin_sync_reg[0];
   wire sclk_rise = pin_sync_reg[1] & ~pin_prev_reg[1];
   wire stb_rise = pin_sync_reg[2] & ~pin_prev_reg[2];
   wire stb_fall = ~pin_sync_reg[2] & pin_prev_reg[2];
   wire hsync_s = pin_sync_reg[3];
   wire hsync_rise = pin_sync_reg[3] & ~pin_prev_reg[3];
   wire hold_s = pin_sync_reg[4];

   ////////////////////////////////////////////////////////////////////////
   // Serial shift register
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] shift_reg;

   // First bit ends up in bit 7
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_reg <= 8'h00;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[6:0], data_s};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   ////////////////////////////////////////////////////////////////////////
   logic bank_reg;
   logic test_reg;
   wire [7:0] w = shift_reg;
   wire b0 = ~bank_reg & ~test_reg;
   wire b1 = bank_reg & ~test_reg;
   wire is_fmt = w[7:2] == `OSD_PFX_FMT;
   wire is_tst = bank_reg & (w[7:4] == `OSD_PFX_TEST);
   wire is_chr = b0 & ~w[7];
   wire is_attr = b0 & (w[7:4] == `OSD_PFX_ATTR);
   wire is_row = b0 & (w[7:4] == `OSD_PFX_ROW);
   wire is_col = b0 & (w[7:5] == `OSD_PFX_COL);
   wire is_bg = b0 & (w[7:5] == `OSD_PFX_BG);
   wire is_ctl = b0 & (w[7:4] == `OSD_PFX_CTL);
   wire is_frg = b0 & (w[7:2] == `OSD_PFX_FRG);
   wire is_vp = b1 & (w[7:6] == `OSD_PFX_VPOS);
   wire is_hp = b1 & (w[7:5] == `OSD_PFX_HPOS);
   wire is_sz = b1 & (w[7:6] == `OSD_PFX_SIZE);
   // Strobe commits the word; format words win over bank 1 test words
   wire ex = stb_rise;
   wire fmt_go = ex & is_fmt;
   wire fr_go = fmt_go & w[0];
   wire tst_go = ex & is_tst & ~is_fmt;
   wire rel_go = tst_go & (w[3:0] == `OSD_TEST_RELEASE);

   ////////////////////////////////////////////////////////////////////////
   // Bank and test mode
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] tcode_reg;

   // Test mode is entered at reset, left by format reset or release code
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bank_reg <= `OSD_RST_BANK;
         test_reg <= `OSD_RST_TEST;
         tcode_reg <= 4'h0;
      end else begin
         if (fmt_go) begin
            bank_reg <= w[1];
         end
         if (fr_go | rel_go) begin
            test_reg <= 1'b0;
         end else if (tst_go) begin
            test_reg <= 1'b1;
         end
         if (tst_go) begin
            tcode_reg <= w[3:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write address and character store
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] row_reg;
   logic [4:0] col_reg;
   logic chr_pend_reg;
   osd_attr_t attr_reg;
   osd_cell_t mem [ROWS][COLS];
   wire col_last = col_reg == 5'(COLS - 1);
   wire row_last = row_reg == 4'(ROWS - 1);
   wire in_range = (row_reg < 4'(ROWS)) & (col_reg < 5'(COLS));

   // Column steps along a row, then wraps into the next row
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         row_reg <= 4'h0;
         col_reg <= 5'h00;
         chr_pend_reg <= 1'b0;
         attr_reg <= '0;
      end else begin
         if (ex) begin
            chr_pend_reg <= is_chr;
         end else if (stb_fall) begin
            chr_pend_reg <= 1'b0;
         end
         if (ex & is_attr) begin
            attr_reg <= w[3:0];
         end
         if (ex & is_row) begin
            row_reg <= w[3:0];
         end else if (stb_fall & chr_pend_reg & col_last) begin
            row_reg <= row_last ? 4'h0 : row_reg + 4'h1;
         end
         if (ex & is_col) begin
            col_reg <= w[4:0];
         end else if (stb_fall & chr_pend_reg) begin
            col_reg <= col_last ? 5'h00 : col_reg + 5'h01;
         end
      end
   end

   // Character store has no reset; addresses past the screen are dropped
   always_ff @(posedge clk_i) begin
      if (ex & is_chr & in_range) begin
         mem[row_reg][col_reg] <= {w[6:0], attr_reg};
      end
   end

   // Registered read for the raster side
   wire scan_ok = (scan_row_i < 4'(ROWS)) & (scan_col_i < 5'(COLS));
   always_ff @(posedge clk_i) begin
      if (rst_i | ~scan_ok) begin
         scan_cell_o <= {`OSD_OFF_CODE, 4'h0};
      end else begin
         scan_cell_o <= mem[scan_row_i][scan_col_i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Display settings
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] ctl_reg;
   logic [1:0] frg_reg;
   logic [4:0] bg_reg;
   logic [5:0] vp_reg;
   logic [4:0] hp_reg;

   // Oscillator enable defaults off so nothing runs before setup
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_reg <= 4'h0;
         frg_reg <= 2'h0;
         bg_reg <= 5'h00;
         vp_reg <= 6'h00;
         hp_reg <= 5'h00;
      end else if (ex) begin
         if (is_ctl) begin
            ctl_reg <= w[3:0];
         end
         if (is_frg) begin
            frg_reg <= w[1:0];
         end
         if (is_bg) begin
            bg_reg <= w[4:0];
         end
         if (is_vp) begin
            vp_reg <= w[5:0];
         end
         if (is_hp) begin
            hp_reg <= w[4:0];
         end
      end
   end

   // One size register per row, cleared together by format reset
   genvar r;
   generate
      for (r = 0; r < ROWS; r++) begin : g_size
         logic [1:0] size_reg;
         always_ff @(posedge clk_i) begin
            if (rst_i | fr_go) begin
               size_reg <= `OSD_RST_SIZE;
            end else if (ex & is_sz & (w[3:0] == 4'(r))) begin
               size_reg <= w[5:4];
            end
         end
         assign char_size_o[2*r +: 2] = size_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Busy
   ////////////////////////////////////////////////////////////////////////
   logic busy_reg;

   // High from strobe rise until the strobe falls and the step settles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_reg <= 1'b0;
      end else if (ex) begin
         busy_reg <= 1'b1;
      end else if (~pin_sync_reg[2] & ~pin_prev_reg[2]) begin
         // One clock past the fall, so the address step is still covered
         busy_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Dot oscillator
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] osc_cnt_reg;
   logic osc_reg;
   wire osc_run = hsync_s & hold_s & ctl_reg[0];
   wire [3:0] half = vp_reg[5] ? `OSD_OSC_HALF_DS : `OSD_OSC_HALF;
   wire osc_wrap = osc_cnt_reg == half - 4'h1;

   // Phase restarts on each sync rise so dots line up with the line
   always_ff @(posedge clk_i) begin
      if (rst_i | ~osc_run | hsync_rise) begin
         osc_cnt_reg <= 4'h0;
         osc_reg <= 1'b0;
      end else if (osc_wrap) begin
         osc_cnt_reg <= 4'h0;
         osc_reg <= ~osc_reg;
      end else begin
         osc_cnt_reg <= osc_cnt_reg + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Video outputs
   ////////////////////////////////////////////////////////////////////////
   logic [2:0] rgb_reg;
   wire cell_on = scan_cell_o.char_code != `OSD_OFF_CODE;
   wire vid_on = hold_s & ctl_reg[3] & osc_run & cell_on;
   wire [2:0] rgb_next = vid_on ? {scan_cell_o.attr.red,
      scan_cell_o.attr.green, scan_cell_o.attr.blue} : 3'h0;

   // Hold forces colour low through vid_on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rgb_reg <= 3'h0;
      end else begin
         rgb_reg <= rgb_next;
      end
   end

   // Output mapping
   assign busy_o = busy_reg;
   assign red_char_out_o = rgb_reg[2];
   assign green_char_out_o = rgb_reg[1];
   assign blue_char_out_o = rgb_reg[0];
   assign video_blanking_out_o = |rgb_reg;
   assign char_activity_monitor_o = |rgb_reg;
   assign osc_out_o = osc_reg;
   assign osc_clock_out_o = ~osc_reg;
   assign bank_select_bit_o = bank_reg;
   assign test_mode_o = test_reg;
   assign test_code_o = tcode_reg;
   assign row_index_o = row_reg;
   assign column_index_o = col_reg;
   assign char_attr_o = attr_reg;
   assign display_enable_o = ctl_reg[3];
   assign blink_rate_o = ctl_reg[2:1];
   assign osc_enable_o = ctl_reg[0];
   assign fringe_ctrl_o = frg_reg;
   assign background_style_o = bg_reg[4:3];
   assign background_color_o = bg_reg[2:0];
   assign double_speed_select_o = vp_reg[5];
   assign vertical_position_o = vp_reg[4:0];
   assign horizontal_position_o = hp_reg;

endmodule : osd_serial_command_decoder

// *** src/osd_params.svh ***
/*
 Constants for the serial command decoder: command prefixes, reset values
 and oscillator timing. Assumes inclusion by bare name from src/.
*/
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH
// Command prefixes on the upper data bits
`define OSD_PFX_FMT 6'h3F
`define OSD_PFX_ATTR 4'h8
`define OSD_PFX_ROW 4'h9
`define OSD_PFX_COL 3'h5
`define OSD_PFX_BG 3'h6
`define OSD_PFX_CTL 4'hE
`define OSD_PFX_FRG 6'h3C
`define OSD_PFX_VPOS 2'h1
`define OSD_PFX_HPOS 3'h6
`define OSD_PFX_SIZE 2'h2
`define OSD_PFX_TEST 4'hE
// Test code that leaves test mode without resetting sizes
`define OSD_TEST_RELEASE 4'h0
// Reset values
`define OSD_RST_TEST 1'b1
`define OSD_RST_BANK 1'b0
`define OSD_RST_SIZE 2'h0
`define OSD_OFF_CODE 7'h7F
// Dot clock half periods in system clocks, normal and double speed
`define OSD_OSC_HALF 4'h4
`define OSD_OSC_HALF_DS 4'h2
`endif

// *** src/osd_pkg.sv ***
/*
 Types shared by the command decoder: character attributes and cells.
 Assumes nothing of its surroundings.
*/
package osd_pkg;
   // Colour and blink attribute of one character
   typedef struct packed {
      logic blink;
      logic red;
      logic green;
      logic blue;
   } osd_attr_t;
   // One stored character cell
   typedef struct packed {
      logic [6:0] char_code;
      osd_attr_t attr;
   } osd_cell_t;
endpackage : osd_pkg

// *** tb/osd_decoder_checker.sv ***
/*
 Port checker for the serial command decoder, bound to its top module.
 Assumes one clock domain, clk_i, with synchronous reset rst_i.
*/
`timescale 1ns/1ps
module osd_decoder_checker #(
   parameter int ROWS = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic command_strobe_i,
   input wire logic hsync_i,
   input wire logic hold_i,
   input wire logic busy_o,
   input wire logic red_char_out_o,
   input wire logic green_char_out_o,
   input wire logic blue_char_out_o,
   input wire logic video_blanking_out_o,
   input wire logic char_activity_monitor_o,
   input wire logic osc_out_o,
   input wire logic osc_clock_out_o,
   input wire logic bank_select_bit_o,
   input wire logic [4:0] column_index_o,
   input wire logic display_enable_o,
   input wire logic [2*ROWS-1:0] char_size_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Colour summary; pins pass synchronisers, hence the long antecedents
   wire logic any_colour = red_char_out_o | green_char_out_o | blue_char_out_o;
   wire logic dark = !(any_colour | video_blanking_out_o);
   sequence s_hold_low; (!hold_i)[*5]; endsequence
   sequence s_sync_low; (!hsync_i)[*6]; endsequence
   //////////////////////////////////////////////////////////////////////
   property p_monitor; char_activity_monitor_o == any_colour; endproperty
   a_monitor: assert property (p_monitor)
      else $error("monitor differs from colour outputs");
   property p_osc_clock_out; osc_clock_out_o != osc_out_o; endproperty
   a_osc_clock_out: assert property (p_osc_clock_out)
      else $error("clock output not inverse of oscillator");
   property p_hold; s_hold_low |=> dark && $stable(osc_out_o); endproperty
   a_hold: assert property (p_hold)
      else $error("video or oscillator active while held");
   property p_sync; s_sync_low |=> $stable(osc_out_o); endproperty
   a_sync: assert property (p_sync)
      else $error("oscillator runs with sync low");
   property p_busy_rise; $rose(busy_o) |-> command_strobe_i; endproperty
   a_busy_rise: assert property (p_busy_rise)
      else $error("busy rose without strobe");
   property p_busy_fall; $fell(busy_o) |-> !command_strobe_i; endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("busy fell while strobe high");
   property p_bank; $changed(bank_select_bit_o) |-> busy_o; endproperty
   a_bank: assert property (p_bank)
      else $error("bank changed outside a command");
   property p_size; $changed(char_size_o) |-> busy_o; endproperty
   a_size: assert property (p_size)
      else $error("sizes changed outside a command");
   property p_col; $changed(column_index_o) |-> busy_o; endproperty
   a_col: assert property (p_col)
      else $error("column changed outside a command");
   property p_blank; (!display_enable_o)[*2] |-> !any_colour; endproperty
   a_blank: assert property (p_blank)
      else $error("colour shown with display off");
endmodule : osd_decoder_checker
bind osd_serial_command_decoder osd_decoder_checker #(.ROWS(ROWS)) u_chk (
   .clk_i, .rst_i, .command_strobe_i, .hsync_i, .hold_i, .busy_o,
   .red_char_out_o, .green_char_out_o, .blue_char_out_o,
   .video_blanking_out_o, .char_activity_monitor_o, .osc_out_o,
   .osc_clock_out_o, .bank_select_bit_o, .column_index_o,
   .display_enable_o, .char_size_o);

// *** tb/osd_host_model.sv ***
/*
 Host model: shifts command words in MSB first and strobes them.
 Assumes clk_i is the decoder clock; the bench calls send_word.
*/
`timescale 1ns/1ps
module osd_host_model (
   input wire logic clk_i,
   input wire logic busy_i,
   output logic serial_data_o,
   output logic serial_clk_o,
   output logic command_strobe_o
);
   initial begin
      serial_data_o = 1'b0;
      serial_clk_o = 1'b0;
      command_strobe_o = 1'b0;
   end
   // Busy is sampled mid-cycle so it never races the edge that sets it
   // A busy line stuck high is left to the bench watchdog
   task automatic wait_ready();
      do begin
         @(negedge clk_i);
      end while (busy_i !== 1'b0);
      @(posedge clk_i);
   endtask : wait_ready
   // Five clocks a level gives the 80 ns link period
   task automatic send_word(input logic [7:0] w);
      wait_ready();
      for (int i = 7; i >= 0; i--) begin
         serial_data_o <= w[i];
         serial_clk_o <= 1'b0;
         repeat (5) @(posedge clk_i);
         serial_clk_o <= 1'b1;
         repeat (5) @(posedge clk_i);
      end
      serial_clk_o <= 1'b0; // Link clock stands still between frames
      serial_data_o <= ~w[0]; // Released line shows the inverse
      command_strobe_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      command_strobe_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      wait_ready();
   endtask : send_word
endmodule : osd_host_model

// *** tb/osd_serial_command_decoder_bench.sv ***
/*
 Self-checking bench for the serial command decoder.
 Assumes the host model drives the serial pins; the bench drives the rest.
*/
`timescale 1ns/1ps
`include "osd_params.svh"
module osd_serial_command_decoder_bench;
   import osd_pkg::*;
   logic clk_i, rst_i, hsync_i, hold_i;
   logic serial_data_i, serial_clk_i, command_strobe_i;
   logic [3:0] scan_row_i;
   logic [4:0] scan_col_i;
   logic busy_o, red_char_out_o, green_char_out_o, blue_char_out_o;
   logic video_blanking_out_o, char_activity_monitor_o;
   logic osc_out_o, osc_clock_out_o, bank_select_bit_o, test_mode_o;
   logic display_enable_o, osc_enable_o, double_speed_select_o;
   logic [3:0] test_code_o, row_index_o;
   logic [4:0] column_index_o, vertical_position_o, horizontal_position_o;
   logic [1:0] blink_rate_o, fringe_ctrl_o, background_style_o;
   logic [2:0] background_color_o;
   logic [23:0] char_size_o;
   osd_cell_t scan_cell_o;
   osd_attr_t char_attr_o;
   int failures = 0;
   int tests_run = 0;
   int toggles = 0;
   logic osc_seen;
   osd_serial_command_decoder dut (.clk_i, .rst_i, .serial_data_i,
      .serial_clk_i, .command_strobe_i, .hsync_i, .hold_i, .scan_row_i,
      .scan_col_i, .busy_o, .red_char_out_o, .green_char_out_o,
      .blue_char_out_o, .video_blanking_out_o, .char_activity_monitor_o,
      .osc_out_o, .osc_clock_out_o, .scan_cell_o, .bank_select_bit_o,
      .test_mode_o, .test_code_o, .row_index_o, .column_index_o,
      .char_attr_o, .display_enable_o, .blink_rate_o, .osc_enable_o,
      .fringe_ctrl_o, .background_style_o, .background_color_o,
      .double_speed_select_o, .vertical_position_o,
      .horizontal_position_o, .char_size_o);
   osd_host_model host (.clk_i, .busy_i(busy_o),
      .serial_data_o(serial_data_i), .serial_clk_o(serial_clk_i),
      .command_strobe_o(command_strobe_i));
   //////////////////////////////////////////////////////////////////////
   // Compare off the clock edge so outputs have settled
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      @(negedge clk_i);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task automatic cmd(input logic [7:0] w);
      host.send_word(w);
   endtask : cmd
   //////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // About 20 commands of roughly 100 clocks each; far below this bound
   initial begin
      repeat (30000) @(posedge clk_i);
      failures++;
      close_out();
   end
   initial begin
      rst_i = 1'b1;
      hold_i = 1'b1;
      hsync_i = 1'b1;
      scan_row_i = 4'h3;
      scan_col_i = 5'h05;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      check(test_mode_o, 1'b1);
      cmd(8'h93);
      check(row_index_o, 4'h0);
      cmd(8'hFD);
      check({test_mode_o, bank_select_bit_o}, 2'b00);
      cmd(8'h93);
      check(row_index_o, 4'h3);
      cmd(8'hA5);
      check(column_index_o, 5'h05);
      cmd(8'h8B);
      check(char_attr_o, 4'hB);
      fork
         cmd(8'h41);
         begin
            @(posedge command_strobe_i);
            repeat (5) @(posedge clk_i);
            check(busy_o, 1'b1);
         end
      join
      check(column_index_o, 5'h06);
      check(scan_cell_o, {7'h41, 4'hB});
      cmd(8'hB7);
      cmd(8'h20);
      check({row_index_o, column_index_o}, {4'h4, 5'h00});
      cmd(8'hEF);
      check({display_enable_o, blink_rate_o, osc_enable_o}, 4'hF);
      cmd(8'hF2);
      check(fringe_ctrl_o, 2'h2);
      cmd(8'hD5);
      check({background_style_o, background_color_o}, 5'h15);
      cmd(8'hFE);
      check(bank_select_bit_o, 1'b1);
      cmd(8'h75);
      check({double_speed_select_o, vertical_position_o}, 6'h35);
      cmd(8'hCA);
      check(horizontal_position_o, 5'h0A);
      cmd(8'hB3);
      check(char_size_o, 24'h0000C0);
      cmd(8'h93);
      check({row_index_o, char_size_o}, {4'h4, 24'h000040});
      cmd(8'hFF);
      check({bank_select_bit_o, char_size_o}, {1'b1, 24'h0});
      cmd(8'hE5);
      check({test_mode_o, test_code_o}, 5'h15);
      cmd(8'h60);
      check(vertical_position_o, 5'h15);
      cmd(8'hE0);
      check(test_mode_o, 1'b0);
      repeat (12) @(posedge clk_i);
      check({red_char_out_o, green_char_out_o, blue_char_out_o}, 3'h3);
      check(char_activity_monitor_o, 1'b1);
      @(posedge clk_i);
      hsync_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      check(osc_out_o, 1'b0);
      check(osc_clock_out_o, 1'b1);
      @(posedge clk_i);
      hsync_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(char_activity_monitor_o, 1'b1);
      // Colour is back on, so hold alone must take it down
      @(posedge clk_i);
      hold_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      check({red_char_out_o, green_char_out_o, blue_char_out_o,
         video_blanking_out_o, char_activity_monitor_o}, 5'h00);
      check(osc_out_o, 1'b0);
      @(posedge clk_i);
      hold_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      // Double speed is set: count dot clock flips over 32 clocks
      @(negedge clk_i);
      osc_seen = osc_out_o;
      repeat (32) begin
         @(negedge clk_i);
         if (osc_out_o !== osc_seen) begin
            toggles++;
         end
         osc_seen = osc_out_o;
      end
      check(toggles, 32 / `OSD_OSC_HALF_DS);
      close_out();
   end
endmodule : osd_serial_command_decoder_bench
